/* File: design/via_map.svh */
// constants of the vectored interrupt arbiter: counts, entry address, slot bytes, reset values
`ifndef VIA_MAP_SVH
`define VIA_MAP_SVH
`define VIA_SRC_COUNT 8
`define VIA_ACK_CYCLES 7
`define VIA_ENTRY_ADDR 15'h00ff
`define VIA_BLOCK_LAST 8'hff
`define VIA_SLOT_TRAP 8'hfe
`define VIA_SLOT_EXT 8'hfa
`define VIA_SLOT_T0 8'hf8
`define VIA_SLOT_T1A 8'hf6
`define VIA_SLOT_T1B 8'hf4
`define VIA_SLOT_SERIAL 8'hf2
`define VIA_SLOT_T2A 8'hea
`define VIA_SLOT_T2B 8'he8
`define VIA_SLOT_WAKE 8'he2
`define VIA_SLOT_DEFAULT 8'he0
`define VIA_RST_FLAG 1'b0
`define VIA_RST_GIE 1'b0
`endif

/* File: design/via_pkg.sv */
// types shared by the vectored interrupt arbiter files
package via_pkg;
   typedef logic [14:0] via_addr_t;
   typedef logic [7:0] via_byte_t;
   typedef enum logic [1:0] {st_idle, st_ack, st_vis_hi, st_vis_lo} via_state_e;
endpackage

/* File: design/via_flag_cell.sv */
// one maskable source: its pending flag and its enable bit
`timescale 1ns/1ps
`include "via_map.svh"
module via_flag_cell (
   input wire logic i_core_clk,
   input wire logic i_rst_b,
   input wire logic i_ce,
   input wire logic i_evt,
   input wire logic i_pend_wr,
   input wire logic i_pend_data,
   input wire logic i_en_wr,
   input wire logic i_en_data,
   output logic o_pend,
   output logic o_enable
);
   // the event strobe beats a software clear in the same cycle, so no event is lost
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_b)
         o_pend <= `VIA_RST_FLAG;
      else if (i_ce)
      begin
         if (i_evt)
            o_pend <= 1'b1;
         else if (i_pend_wr)
            o_pend <= i_pend_data;
      end
   end

   // enable bit, written by software only
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_b)
         o_enable <= `VIA_RST_FLAG;
      else if (i_ce && i_en_wr)
         o_enable <= i_en_data;
   end

   a_pend_sets:
   assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      i_ce && i_evt |=> o_pend)
      else $error("pending flag not set by event");

   a_zero_clears:
   assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      i_ce && i_pend_wr && !i_pend_data && !i_evt |=> !o_pend)
      else $error("pending flag not cleared by zero write");
endmodule

/* File: design/via_rank_encoder.sv */
// fixed-rank encoder: highest active source to its vector slot byte
`timescale 1ns/1ps
`include "via_map.svh"
module via_rank_encoder #(
   parameter int SRC_COUNT = `VIA_SRC_COUNT
) (
   input wire logic [SRC_COUNT-1:0] i_active,
   input wire logic i_trap,
   output via_pkg::via_byte_t o_slot
);
   import via_pkg::*;

   // slot of each maskable source, index 0 ranked highest
   localparam via_byte_t SLOT [0:7] = '{`VIA_SLOT_EXT, `VIA_SLOT_T0, `VIA_SLOT_T1A,
      `VIA_SLOT_T1B, `VIA_SLOT_SERIAL, `VIA_SLOT_T2A, `VIA_SLOT_T2B, `VIA_SLOT_WAKE};

   // scan from lowest rank upward so the highest active one is written last
   always_comb
   begin
      o_slot = `VIA_SLOT_DEFAULT;
      for (int i = SRC_COUNT - 1; i >= 0; i--)
      begin
         if (i_active[i])
            o_slot = SLOT[i];
      end
      if (i_trap)
         o_slot = `VIA_SLOT_TRAP;
   end
endmodule

/* File: design/via_arbiter.sv */
// top of the vectored interrupt arbiter: flags, gating, acknowledge and vector select
`timescale 1ns/1ps
`include "via_map.svh"
////////////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////////////
module via_arbiter #(
   parameter int SRC_COUNT = `VIA_SRC_COUNT,
   parameter int ACK_CYCLES = `VIA_ACK_CYCLES
) (
   input wire logic i_core_clk,
   input wire logic i_rst_b,
   input wire logic i_ce,
   input wire logic [SRC_COUNT-1:0] i_evt,
   input wire logic i_pend_wr,
   input wire logic [SRC_COUNT-1:0] i_pend_data,
   input wire logic i_en_wr,
   input wire logic [SRC_COUNT-1:0] i_en_data,
   input wire logic i_gie_wr,
   input wire logic i_gie_data,
   input wire logic i_trap,
   input wire logic i_clr_trap,
   input wire logic i_instr_start,
   input wire logic i_skip_next,
   input wire via_pkg::via_addr_t i_ret_addr,
   input wire logic i_return_from_service,
   input wire via_pkg::via_addr_t i_pop_addr,
   input wire logic i_vis_start,
   input wire via_pkg::via_addr_t i_vis_pc,
   input wire logic i_rom_valid,
   input wire via_pkg::via_byte_t i_rom_byte,
   output logic [SRC_COUNT-1:0] o_pending,
   output logic [SRC_COUNT-1:0] o_enable,
   output logic o_gie,
   output logic o_trap_pending,
   output logic o_ack_busy,
   output logic o_push_valid,
   output via_pkg::via_addr_t o_push_addr,
   output logic o_pc_load,
   output via_pkg::via_addr_t o_pc_value,
   output logic o_vis_load,
   output via_pkg::via_addr_t o_vis_addr
);
   import via_pkg::*;
   localparam logic [3:0] ACK_LAST = 4'(ACK_CYCLES);
   via_state_e state;
   via_state_e next_state;
   logic [3:0] ack_cnt;
   logic [3:0] next_ack_cnt;
   logic trap_owed;
   logic [SRC_COUNT-1:0] active;
   logic boundary;
   logic take_trap;
   logic take_mask;
   logic take;
   logic vis_go;
   via_byte_t enc_slot;
   logic [6:0] vis_block;
   logic [6:0] vec_hi;
   ////////////////////////////////////////////////////////////////////////////
   // per-source flags; one cell each keeps the set-over-clear behaviour local
   for (genvar g = 0; g < SRC_COUNT; g++)
   begin : g_src
      via_flag_cell u_cell (
         .i_core_clk(i_core_clk),
         .i_rst_b(i_rst_b),
         .i_ce(i_ce),
         .i_evt(i_evt[g]),
         .i_pend_wr(i_pend_wr),
         .i_pend_data(i_pend_data[g]),
         .i_en_wr(i_en_wr),
         .i_en_data(i_en_data[g]),
         .o_pend(o_pending[g]),
         .o_enable(o_enable[g])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // request gating
   // a source is active once both its bits are set, whatever order they came in
   assign active = o_enable & o_pending;

   // only a normally executed instruction opens a window; a skipped one is stepped over
   assign boundary = i_ce && i_instr_start && !i_skip_next && (state == st_idle);

   // the trap is not maskable and wins over every maskable request
   assign take_trap = boundary && trap_owed;

   // maskable requests wait while the trap pending flag shows a trap in service
   assign take_mask = boundary && !trap_owed && (|active) && o_gie && !o_trap_pending;
   assign take = take_trap || take_mask;
   // vector select is served only when no acknowledge is starting
   assign vis_go = i_ce && i_vis_start && (state == st_idle) && !take;

   ////////////////////////////////////////////////////////////////////////////
   // rank encoder for the vector-select instruction
   via_rank_encoder #(
      .SRC_COUNT(SRC_COUNT)
   ) u_rank (
      .i_active(active),
      .i_trap(o_trap_pending),
      .o_slot(enc_slot)
   );
   // table block: that of the instruction, or the next one when it sits on the last byte
   assign vis_block = (i_vis_pc[7:0] == `VIA_BLOCK_LAST) ? (i_vis_pc[14:8] + 7'h01)
                                                          : i_vis_pc[14:8];

   ////////////////////////////////////////////////////////////////////////////
   // trap flags
   // the visible flag marks a trap in service; only the clear instruction drops it
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_b)
         o_trap_pending <= `VIA_RST_FLAG;
      else if (i_ce)
      begin
         if (i_trap)
            o_trap_pending <= 1'b1;
         else if (i_clr_trap)
            o_trap_pending <= 1'b0;
      end
   end

   // a trap still owes its acknowledge until the next boundary takes it
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_b)
         trap_owed <= 1'b0;
      else if (i_ce)
      begin
         if (i_trap)
            trap_owed <= 1'b1;
         else if (take_trap)
            trap_owed <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // global enable: acknowledge clears it ahead of return and software writes
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_b)
         o_gie <= `VIA_RST_GIE;
      else if (i_ce)
      begin
         if (take)
            o_gie <= 1'b0;
         else if (i_return_from_service)
            o_gie <= 1'b1;
         else if (i_gie_wr)
            o_gie <= i_gie_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sequencer state
   always_comb
   begin
      next_state = state;
      next_ack_cnt = ack_cnt;
      unique case (state)
         st_idle:
         begin
            if (take)
            begin
               next_state = st_ack;
               next_ack_cnt = 4'h1;
            end
            else if (vis_go)
               next_state = st_vis_hi;
         end
         st_ack:
         begin
            if (ack_cnt == ACK_LAST)
            begin
               next_state = st_idle;
               next_ack_cnt = 4'h0;
            end
            else
               next_ack_cnt = ack_cnt + 4'h1;
         end
         st_vis_hi:
         begin
            if (i_rom_valid)
               next_state = st_vis_lo;
         end
         st_vis_lo:
         begin
            if (i_rom_valid)
               next_state = st_idle;
         end
      endcase
   end

   // state and counter freeze together with the clock enable
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_b)
      begin
         state <= st_idle;
         ack_cnt <= 4'h0;
      end
      else if (i_ce)
      begin
         state <= next_state;
         ack_cnt <= next_ack_cnt;
      end
   end

   // busy covers the whole acknowledge so the core holds off fetching
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_b)
         o_ack_busy <= 1'b0;
      else if (i_ce)
         o_ack_busy <= (next_state == st_ack);
   end

   ////////////////////////////////////////////////////////////////////////////
   // return address push, a single pulse in the first acknowledge cycle
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_b)
      begin
         o_push_valid <= 1'b0;
         o_push_addr <= 15'h0000;
      end
      else if (i_ce)
      begin
         o_push_valid <= take;
         if (take)
            o_push_addr <= i_ret_addr;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // program counter loads: entry point, vector target, popped return address
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_b)
      begin
         o_pc_load <= 1'b0;
         o_pc_value <= 15'h0000;
      end
      else if (i_ce)
      begin
         o_pc_load <= 1'b0;
         if (state == st_ack && ack_cnt == ACK_LAST - 4'h1)
         begin
            o_pc_load <= 1'b1;
            o_pc_value <= `VIA_ENTRY_ADDR;
         end
         else if (state == st_vis_lo && i_rom_valid)
         begin
            o_pc_load <= 1'b1;
            o_pc_value <= {vec_hi, i_rom_byte};
         end
         else if (state == st_idle && !take && i_return_from_service)
         begin
            o_pc_load <= 1'b1;
            o_pc_value <= i_pop_addr;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // vector-select: the rank is sampled only in the instruction's first cycle
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_b)
      begin
         o_vis_load <= 1'b0;
         o_vis_addr <= 15'h0000;
      end
      else if (i_ce)
      begin
         o_vis_load <= vis_go;
         if (vis_go)
            o_vis_addr <= {vis_block, enc_slot};
      end
   end

   // high vector byte arrives first; bit 7 is dropped since the space is 15 bits
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_b)
         vec_hi <= 7'h00;
      else if (i_ce && state == st_vis_hi && i_rom_valid)
         vec_hi <= i_rom_byte[6:0];
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   a_reset_clear:
   assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      $rose(i_rst_b) |-> !o_gie && o_pending == '0 && o_enable == '0 && !o_trap_pending)
      else $error("flags not cleared by reset");

   a_mask_gate:
   assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      $rose(o_ack_busy) && !$past(trap_owed) |-> $past(o_gie) && !$past(o_trap_pending) && (|$past(active)))
      else $error("maskable request taken without all conditions");

   a_entry_seven:
   assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      take ##1 i_ce [*6] |=> o_pc_load && o_pc_value == `VIA_ENTRY_ADDR && o_ack_busy && $past(o_ack_busy, 6))
      else $error("entry load not in seventh acknowledge cycle");

   a_push_gie:
   assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      take |=> o_push_valid && !o_gie && o_push_addr == $past(i_ret_addr))
      else $error("acknowledge did not push or clear global enable");

   a_boundary_only:
   assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      $rose(o_ack_busy) |-> $past(i_instr_start) && !$past(i_skip_next))
      else $error("acknowledge started off an instruction boundary");

   a_trap_slot:
   assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      vis_go && o_trap_pending |=> o_vis_load && o_vis_addr[7:0] == `VIA_SLOT_TRAP)
      else $error("trap did not select the top slot");

   a_default_slot:
   assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      vis_go && !o_trap_pending && (o_enable & o_pending) == '0 |=> o_vis_addr[7:0] == `VIA_SLOT_DEFAULT)
      else $error("idle vector select missed the default slot");

   a_vis_block:
   assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      vis_go |=> o_vis_addr[14:8] == ($past(i_vis_pc[7:0]) == `VIA_BLOCK_LAST ?
                 7'($past(i_vis_pc[14:8]) + 7'h01) : $past(i_vis_pc[14:8])))
      else $error("vector table block wrong");

   a_return_from_service_gie:
   assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      i_ce && i_return_from_service && !take |=> o_gie)
      else $error("return did not set global enable");

   a_vec_pair:
   assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      i_ce && state == st_vis_lo && i_rom_valid |=> o_pc_load && o_pc_value[7:0] == $past(i_rom_byte))
      else $error("vector low byte not loaded");
endmodule

/* File: sim/via_rom_model.sv */
// program memory model: returns the two vector table bytes after a vector select
`timescale 1ns/1ps
module via_rom_model (
   input wire logic i_core_clk,
   input wire logic i_slow,
   input wire logic i_vis_load,
   input wire via_pkg::via_addr_t i_vis_addr,
   output logic o_rom_valid,
   output via_pkg::via_byte_t o_rom_byte
);
   import via_pkg::*;
   via_byte_t slot;
   logic [1:0] phase;
   ////////////////////////////////////////////////////////////////////////////////
   // fetch sequencer; between bytes the data lines show the inverse, never a stale byte
   initial
   begin
      o_rom_valid = 1'b0;
      o_rom_byte = 8'h00;
      phase = 2'h0;
      slot = 8'h00;
   end
   always @(posedge i_core_clk)
   begin
      if (i_vis_load)
      begin
         slot <= i_vis_addr[7:0];
         o_rom_valid <= 1'b1;
         o_rom_byte <= {1'b1, i_vis_addr[6:0]}; // high byte first, bit 7 set to prove it is dropped
         phase <= 2'h1;
      end
      else if (phase == 2'h1 && i_slow)
      begin
         o_rom_valid <= 1'b0;
         o_rom_byte <= ~o_rom_byte;
         phase <= 2'h3;
      end
      else if (phase == 2'h1 || phase == 2'h3)
      begin
         o_rom_valid <= 1'b1;
         o_rom_byte <= slot ^ 8'h5a; // low byte second
         phase <= 2'h2;
      end
      else
      begin
         o_rom_valid <= 1'b0;
         o_rom_byte <= ~o_rom_byte;
         phase <= 2'h0;
      end
   end
endmodule

/* File: sim/via_arbiter_tb.sv */
// self-checking bench of the vectored interrupt arbiter
`timescale 1ns/1ps
module via_arbiter_tb;
   import via_pkg::*;
   typedef struct {logic [7:0] pe; logic [7:0] en; logic tr; via_addr_t pc; via_addr_t va;} via_row_s;
   logic clk, rst_b, ce, pend_wr, en_wr, gie_wr, gie_data, trap, clr_trap, start, skip, return_from_service, vis_start, slow;
   logic [7:0] evt, pend_data, en_data, pending, enable;
   via_addr_t ret_addr, pop_addr, vis_pc, push_a, pc_val, vis_addr;
   logic global_irq_enable, trap_pend, busy, push_v, pc_load, vis_load, rom_v;
   via_byte_t rom_b;
   int num_errors = 0;
   int num_checks = 0;
   int cyc = 0;
   int n;
   via_row_s rows [12] = '{
      '{8'hff, 8'hff, 1'b0, 15'h0100, 15'h01fa}, '{8'hfe, 8'hff, 1'b0, 15'h01df, 15'h01f8},
      '{8'hfc, 8'hff, 1'b0, 15'h0120, 15'h01f6}, '{8'hf8, 8'hff, 1'b0, 15'h0130, 15'h01f4},
      '{8'hf0, 8'hff, 1'b0, 15'h0140, 15'h01f2}, '{8'he0, 8'hff, 1'b0, 15'h0150, 15'h01ea},
      '{8'hc0, 8'hff, 1'b0, 15'h0160, 15'h01e8}, '{8'h80, 8'hff, 1'b0, 15'h0170, 15'h01e2},
      '{8'hff, 8'h00, 1'b0, 15'h0200, 15'h02e0}, '{8'h01, 8'hfe, 1'b0, 15'h00ff, 15'h01e0},
      '{8'h00, 8'h00, 1'b1, 15'h7eff, 15'h7ffe}, '{8'hff, 8'hff, 1'b1, 15'h0310, 15'h03fe}};
   ////////////////////////////////////////////////////////////////////////////////
   // clock, hang limit and instances
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         num_errors++;
         test_done();
      end
   end
   via_arbiter via_arbiter_inst (.i_core_clk(clk), .i_rst_b(rst_b), .i_ce(ce), .i_evt(evt),
      .i_pend_wr(pend_wr), .i_pend_data(pend_data), .i_en_wr(en_wr), .i_en_data(en_data), .i_gie_wr(gie_wr),
      .i_gie_data(gie_data), .i_trap(trap), .i_clr_trap(clr_trap), .i_instr_start(start), .i_skip_next(skip),
      .i_ret_addr(ret_addr), .i_return_from_service(return_from_service), .i_pop_addr(pop_addr), .i_vis_start(vis_start), .i_vis_pc(vis_pc),
      .i_rom_valid(rom_v), .i_rom_byte(rom_b), .o_pending(pending), .o_enable(enable), .o_gie(global_irq_enable),
      .o_trap_pending(trap_pend), .o_ack_busy(busy), .o_push_valid(push_v), .o_push_addr(push_a),
      .o_pc_load(pc_load), .o_pc_value(pc_val), .o_vis_load(vis_load), .o_vis_addr(vis_addr));
   via_rom_model via_rom_model_inst (.i_core_clk(clk), .i_slow(slow), .i_vis_load(vis_load),
      .i_vis_addr(vis_addr), .o_rom_valid(rom_v), .o_rom_byte(rom_b));
   ////////////////////////////////////////////////////////////////////////////////
   // shared tasks: compare, verdict, reset, register writes, instruction boundary
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task test_done();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task do_reset();
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      #1 chk({pending, enable}, 15'h0);
      chk({global_irq_enable, trap_pend, busy}, 15'h0);
   endtask
   task put(input logic [7:0] ev, input logic pw, input logic [7:0] pd, input logic [7:0] en, input logic g);
      @(posedge clk);
      evt <= ev;
      pend_wr <= pw;
      pend_data <= pd;
      en_wr <= 1'b1;
      en_data <= en;
      gie_wr <= 1'b1;
      gie_data <= g;
      @(posedge clk);
      evt <= 8'h00;
      pend_wr <= 1'b0;
      en_wr <= 1'b0;
      gie_wr <= 1'b0;
      #1;
   endtask
   task boundary(input logic sk, input via_addr_t ra, input logic tk);
      @(posedge clk);
      start <= 1'b1;
      skip <= sk;
      ret_addr <= ra;
      @(posedge clk);
      start <= 1'b0;
      skip <= 1'b0;
      #1 chk(busy, tk);
      if (tk)
      begin
         chk({push_v, global_irq_enable}, 15'h2);
         chk(push_a, ra);
         repeat (6) @(posedge clk);
         #1 chk({busy, pc_load}, 15'h3);
         chk(pc_val, 15'h00ff);
         @(posedge clk);
         #1 chk({busy, pc_load}, 15'h0);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // main sequence: vector select table, then acknowledge and return by hand
   initial
   begin
      {rst_b, pend_wr, en_wr, gie_wr, gie_data, trap, clr_trap, start, skip, return_from_service, vis_start, slow} = 12'h0;
      ce = 1'b1;
      {evt, pend_data, en_data} = 24'h0;
      {ret_addr, pop_addr, vis_pc} = 45'h0;
      do_reset();
      foreach (rows[i])
      begin
         put(8'h00, 1'b1, rows[i].pe, rows[i].en, 1'b0);
         chk(enable, rows[i].en);
         if (rows[i].tr)
         begin
            @(posedge clk);
            trap <= 1'b1;
            @(posedge clk);
            trap <= 1'b0;
            #1 chk(trap_pend, 1'b1);
         end
         @(posedge clk);
         slow <= i[0];
         vis_start <= 1'b1;
         vis_pc <= rows[i].pc;
         @(posedge clk);
         vis_start <= 1'b0;
         #1 chk(vis_load, 1'b1);
         chk(vis_addr, rows[i].va);
         n = 0;
         while (pc_load !== 1'b1 && n < 10)
         begin
            @(posedge clk);
            #1 n++;
         end
         chk(pc_load, 1'b1);
         chk(pc_val, {rows[i].va[6:0], rows[i].va[7:0] ^ 8'h5a});
         if (rows[i].tr)
         begin
            @(posedge clk);
            clr_trap <= 1'b1;
            @(posedge clk);
            clr_trap <= 1'b0;
            #1 chk(trap_pend, 1'b0);
         end
      end
      do_reset();
      put(8'h24, 1'b1, 8'h00, 8'h00, 1'b1);
      chk(pending, 8'h24);
      boundary(1'b0, 15'h0111, 1'b0);
      put(8'h00, 1'b0, 8'h00, 8'h04, 1'b1);
      boundary(1'b1, 15'h0122, 1'b0);
      boundary(1'b0, 15'h0133, 1'b1);
      boundary(1'b0, 15'h0144, 1'b0);
      @(posedge clk);
      return_from_service <= 1'b1;
      pop_addr <= 15'h2345;
      @(posedge clk);
      return_from_service <= 1'b0;
      #1 chk({global_irq_enable, pc_load}, 15'h3);
      chk(pc_val, 15'h2345);
      boundary(1'b0, 15'h0155, 1'b1);
      // inside the routine: clear own flag early and reopen nesting
      put(8'h00, 1'b1, 8'h00, 8'h05, 1'b1);
      chk(pending, 8'h00);
      boundary(1'b0, 15'h0166, 1'b0);
      put(8'h05, 1'b0, 8'h00, 8'h05, 1'b1);
      chk(pending, 8'h05);
      boundary(1'b0, 15'h0177, 1'b1);
      @(posedge clk);
      vis_start <= 1'b1;
      vis_pc <= 15'h00ff;
      @(posedge clk);
      vis_start <= 1'b0;
      #1 chk({vis_load, vis_addr}, 16'h81fa);
      repeat (4) @(posedge clk);
      put(8'h00, 1'b1, 8'h04, 8'h05, 1'b0);
      chk(pending, 8'h04);
      // trap is taken with the global enable off, then blocks maskable requests
      @(posedge clk);
      trap <= 1'b1;
      @(posedge clk);
      trap <= 1'b0;
      boundary(1'b0, 15'h0188, 1'b1);
      put(8'h00, 1'b0, 8'h00, 8'h05, 1'b1);
      boundary(1'b0, 15'h0199, 1'b0);
      @(posedge clk);
      clr_trap <= 1'b1;
      @(posedge clk);
      clr_trap <= 1'b0;
      #1 chk(trap_pend, 1'b0);
      boundary(1'b0, 15'h01aa, 1'b1);
      // an event while the clock enable is low must leave the flags frozen
      @(posedge clk);
      ce <= 1'b0;
      evt <= 8'h80;
      @(posedge clk);
      ce <= 1'b1;
      evt <= 8'h00;
      #1 chk(pending, 8'h04);
      test_done();
   end
endmodule
